//--- common/wit_regs.vh
`ifndef WIT_REGS_VH
`define WIT_REGS_VH

// Write addresses (word writes only), lower 16 address bits.
`define WIT_WR_ADDR_CTRL 16'hffa8
`define WIT_WR_ADDR_RST 16'hffaa

// Read addresses (byte reads), lower 16 address bits.
`define WIT_RD_ADDR_CTRL 16'hffa8
`define WIT_RD_ADDR_COUNT 16'hffa9
`define WIT_RD_ADDR_RST 16'hffab

// Passwords carried in the upper byte of a write word; the clear data goes in the lower byte.
`define WIT_PW_COUNT 8'h5a
`define WIT_PW_CTRL 8'ha5
`define WIT_PW_RST_CLR 8'ha5
`define WIT_PW_RST_OE 8'h5a
`define WIT_RST_CLR_DATA 8'h00

// Field positions in timer_control_status.
`define WIT_CTRL_OVF_BIT 7
`define WIT_CTRL_MODE_BIT 6
`define WIT_CTRL_TME_BIT 5
`define WIT_CTRL_RSVD 2'h3

// Field positions in reset_control_status.
`define WIT_RST_SEEN_BIT 7
`define WIT_RST_OE_BIT 6
`define WIT_RST_RSVD 6'h3f

// Reset values and the count maximum.
`define WIT_CTRL_RESET 8'h18
`define WIT_COUNT_RESET 8'h00
`define WIT_RST_RESET 8'h3f
`define WIT_COUNT_MAX 8'hff

// Prescaler: tap widths in bits, divide = 2**width, code 0 in the low nibble.
`define WIT_PRE_WIDTH 12
`define WIT_TAP_WIDTHS 32'hcb98_7651

// Reset pulse lengths in system clock states; one state is one clock.
`define WIT_STATE_PER_CYCLE 1
`define WIT_INT_RST_STATES 518
`define WIT_EXT_RST_STATES 132
`define WIT_INT_RST_CYC (`WIT_INT_RST_STATES / `WIT_STATE_PER_CYCLE)
`define WIT_EXT_RST_CYC (`WIT_EXT_RST_STATES / `WIT_STATE_PER_CYCLE)

`endif

//--- rtl/wit_prescaler.v
`timescale 1ns/1ps
`include "wit_regs.vh"

module wit_prescaler
(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [2:0] select_in,
    output wire tick_out
);

    reg [`WIT_PRE_WIDTH-1:0] div_ff;
    wire [7:0] tap_tick;
    wire [31:0] tap_widths = `WIT_TAP_WIDTHS;

    // One divider feeds every tap, so switching taps never restarts the count.
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            div_ff <= {`WIT_PRE_WIDTH{1'b0}};
        end
        else
        begin
            div_ff <= div_ff + 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_tap
            wire [3:0] w = tap_widths[gi*4 +: 4];
            wire [`WIT_PRE_WIDTH-1:0] mask = ~({`WIT_PRE_WIDTH{1'b1}} << w);
            assign tap_tick[gi] = &(div_ff | ~mask);
        end
    endgenerate

    assign tick_out = tap_tick[select_in];

endmodule // wit_prescaler

//--- rtl/wit_rstgen.v
`timescale 1ns/1ps
`include "wit_regs.vh"

module wit_rstgen
(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire start_in,
    input wire ext_enable_in,
    output wire int_active_out,
    output wire ext_active_out
);

    // The counts are cut to the counter width on purpose; both fit in ten bits.
    localparam integer INT_LEN_FULL = `WIT_INT_RST_CYC;
    localparam integer EXT_LEN_FULL = `WIT_EXT_RST_CYC;
    localparam [9:0] INT_LEN = INT_LEN_FULL[9:0];
    localparam [9:0] EXT_LEN = EXT_LEN_FULL[9:0];

    reg [9:0] int_cnt_ff;
    reg [9:0] ext_cnt_ff;

    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            int_cnt_ff <= 10'h000;
            ext_cnt_ff <= 10'h000;
        end
        else
        begin
            if (start_in && int_cnt_ff == 10'h000)
            begin
                int_cnt_ff <= INT_LEN;
                ext_cnt_ff <= ext_enable_in ? EXT_LEN : 10'h000;
            end
            else
            begin
                if (int_cnt_ff != 10'h000)
                begin
                    int_cnt_ff <= int_cnt_ff - 10'h001;
                end
                if (ext_cnt_ff != 10'h000)
                begin
                    ext_cnt_ff <= ext_cnt_ff - 10'h001;
                end
            end
        end
    end

    assign int_active_out = (int_cnt_ff != 10'h000);
    assign ext_active_out = (ext_cnt_ff != 10'h000);

endmodule // wit_rstgen

//--- rtl/wit_top.v
`timescale 1ns/1ps
`include "wit_regs.vh"

module wit_top
(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire standby_in,
    input wire [15:0] bus_addr_in,
    input wire [15:0] bus_wdata_in,
    input wire bus_wr_in,
    input wire bus_word_in,
    input wire bus_rd_in,
    output wire [7:0] bus_rdata_out,
    output wire interval_irq_out,
    output wire internal_reset_out,
    output wire reset_output_pin_o_out,
    output wire reset_output_pin_oe_out
);

    // Synchronised copy of the external reset pin.
    reg [1:0] rst_sync_ff;
    wire rst_n;

    // timer_control_status fields.
    reg overflow_flag_ff;
    reg watchdog_or_interval_select_ff;
    reg timer_run_enable_ff;
    reg [2:0] prescaler_select_ff;
    reg nxt_overflow_flag;
    reg nxt_watchdog_or_interval_select;
    reg nxt_timer_run_enable;
    reg [2:0] nxt_prescaler_select;

    // Overflow clear is armed by a read that saw the flag set.
    reg ovf_armed_ff;
    reg nxt_ovf_armed;

    // timer_count.
    reg [7:0] timer_count_ff;
    reg [7:0] nxt_timer_count;

    // reset_control_status fields.
    reg watchdog_reset_seen_ff;
    reg reset_output_enable_ff;
    reg nxt_watchdog_reset_seen;
    reg nxt_reset_output_enable;

    // Read data.
    reg [7:0] rdata_ff;
    reg [7:0] nxt_rdata;

    wire [7:0] wr_hi = bus_wdata_in[15:8];
    wire [7:0] wr_lo = bus_wdata_in[7:0];
    wire word_wr = bus_wr_in & bus_word_in;
    wire wr_count;
    wire wr_ctrl;
    wire wr_rst_clr;
    wire wr_rst_oe;
    wire rd_ctrl;
    wire rd_count;
    wire rd_rst;
    wire [7:0] ctrl_view;
    wire [7:0] rst_view;
    wire count_tick;
    wire ovf_event;
    wire wdt_fire;
    wire int_rst_active;
    wire ext_rst_active;

    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_sync_ff <= 2'h0;
        end
        else
        begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_ff[1];

    // Byte writes match none of these, so they are silently dropped.
    assign wr_count = word_wr && (bus_addr_in == `WIT_WR_ADDR_CTRL)
        && (wr_hi == `WIT_PW_COUNT);
    assign wr_ctrl = word_wr && (bus_addr_in == `WIT_WR_ADDR_CTRL)
        && (wr_hi == `WIT_PW_CTRL);
    assign wr_rst_clr = word_wr && (bus_addr_in == `WIT_WR_ADDR_RST)
        && (wr_hi == `WIT_PW_RST_CLR) && (wr_lo == `WIT_RST_CLR_DATA);
    assign wr_rst_oe = word_wr && (bus_addr_in == `WIT_WR_ADDR_RST)
        && (wr_hi == `WIT_PW_RST_OE);

    assign rd_ctrl = bus_rd_in && (bus_addr_in == `WIT_RD_ADDR_CTRL);
    assign rd_count = bus_rd_in && (bus_addr_in == `WIT_RD_ADDR_COUNT);
    assign rd_rst = bus_rd_in && (bus_addr_in == `WIT_RD_ADDR_RST);

    assign ctrl_view = {overflow_flag_ff, watchdog_or_interval_select_ff,
        timer_run_enable_ff, `WIT_CTRL_RSVD, prescaler_select_ff};
    assign rst_view = {watchdog_reset_seen_ff, reset_output_enable_ff,
        `WIT_RST_RSVD};

    wit_prescaler u_prescaler
    (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .select_in(prescaler_select_ff),
        .tick_out(count_tick)
    );

    // A counter write in the same cycle as a tick wins, so no increment
    // and no overflow can come from that tick.
    assign ovf_event = timer_run_enable_ff && count_tick && !wr_count
        && (timer_count_ff == `WIT_COUNT_MAX);
    assign wdt_fire = ovf_event && watchdog_or_interval_select_ff;

    wit_rstgen u_rstgen
    (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .start_in(wdt_fire),
        .ext_enable_in(reset_output_enable_ff),
        .int_active_out(int_rst_active),
        .ext_active_out(ext_rst_active)
    );

    // Timer control and counter next state.
    always @*
    begin
        nxt_overflow_flag = overflow_flag_ff;
        nxt_watchdog_or_interval_select = watchdog_or_interval_select_ff;
        nxt_timer_run_enable = timer_run_enable_ff;
        nxt_prescaler_select = prescaler_select_ff;
        nxt_ovf_armed = ovf_armed_ff;
        nxt_timer_count = timer_count_ff;

        if (int_rst_active)
        begin
            // The internal chip reset clears this register like a pin reset.
            nxt_overflow_flag = 1'b0;
            nxt_watchdog_or_interval_select = 1'b0;
            nxt_timer_run_enable = 1'b0;
            nxt_prescaler_select = 3'h0;
            nxt_ovf_armed = 1'b0;
        end
        else if (standby_in)
        begin
            nxt_overflow_flag = 1'b0;
            nxt_watchdog_or_interval_select = 1'b0;
            nxt_timer_run_enable = 1'b0;
            nxt_ovf_armed = 1'b0;
        end
        else
        begin
            if (rd_ctrl && overflow_flag_ff)
            begin
                nxt_ovf_armed = 1'b1;
            end
            if (wr_ctrl)
            begin
                nxt_watchdog_or_interval_select = wr_lo[`WIT_CTRL_MODE_BIT];
                nxt_timer_run_enable = wr_lo[`WIT_CTRL_TME_BIT];
                nxt_prescaler_select = wr_lo[2:0];
                nxt_ovf_armed = 1'b0;
                // A one in bit 7 is ignored; a zero clears only when armed.
                if (!wr_lo[`WIT_CTRL_OVF_BIT] && ovf_armed_ff)
                begin
                    nxt_overflow_flag = 1'b0;
                end
            end
            // A new overflow beats a clear in the same cycle.
            if (ovf_event)
            begin
                nxt_overflow_flag = 1'b1;
            end
        end

        if (!timer_run_enable_ff || int_rst_active)
        begin
            nxt_timer_count = `WIT_COUNT_RESET;
        end
        else if (wr_count)
        begin
            nxt_timer_count = wr_lo;
        end
        else if (count_tick)
        begin
            nxt_timer_count = timer_count_ff + 8'h01;
        end
    end

    // Reset control next state; of the resets, only the pin reset clears these bits.
    always @*
    begin
        nxt_watchdog_reset_seen = watchdog_reset_seen_ff;
        nxt_reset_output_enable = reset_output_enable_ff;
        if (wr_rst_clr)
        begin
            nxt_watchdog_reset_seen = 1'b0;
        end
        if (wr_rst_oe)
        begin
            nxt_reset_output_enable = wr_lo[`WIT_RST_OE_BIT];
        end
        if (wdt_fire)
        begin
            nxt_watchdog_reset_seen = 1'b1;
        end
    end

    // Read mux; unmapped addresses return zero.
    always @*
    begin
        nxt_rdata = rdata_ff;
        if (rd_ctrl)
        begin
            nxt_rdata = ctrl_view;
        end
        else if (rd_count)
        begin
            nxt_rdata = timer_count_ff;
        end
        else if (rd_rst)
        begin
            nxt_rdata = rst_view;
        end
        else if (bus_rd_in)
        begin
            nxt_rdata = 8'h00;
        end
    end

    always @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overflow_flag_ff <= 1'b0;
            watchdog_or_interval_select_ff <= 1'b0;
            timer_run_enable_ff <= 1'b0;
            prescaler_select_ff <= 3'h0;
            ovf_armed_ff <= 1'b0;
            timer_count_ff <= `WIT_COUNT_RESET;
            rdata_ff <= 8'h00;
        end
        else
        begin
            overflow_flag_ff <= nxt_overflow_flag;
            watchdog_or_interval_select_ff <= nxt_watchdog_or_interval_select;
            timer_run_enable_ff <= nxt_timer_run_enable;
            prescaler_select_ff <= nxt_prescaler_select;
            ovf_armed_ff <= nxt_ovf_armed;
            timer_count_ff <= nxt_timer_count;
            rdata_ff <= nxt_rdata;
        end
    end

    // Kept in a separate process so the watchdog's own reset never reaches it.
    always @(posedge ref_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            watchdog_reset_seen_ff <= 1'b0;
            reset_output_enable_ff <= 1'b0;
        end
        else
        begin
            watchdog_reset_seen_ff <= nxt_watchdog_reset_seen;
            reset_output_enable_ff <= nxt_reset_output_enable;
        end
    end

    assign bus_rdata_out = rdata_ff;
    // The request follows the flag in interval mode, so it stays high until the flag is cleared or watchdog mode is selected.
    assign interval_irq_out = overflow_flag_ff && !watchdog_or_interval_select_ff;
    assign internal_reset_out = int_rst_active;
    // Open drain: the pin only ever pulls low.
    assign reset_output_pin_o_out = 1'b0;
    assign reset_output_pin_oe_out = ext_rst_active;

endmodule // wit_top

//--- verification/wit_top_props.sv
`timescale 1ns/1ps
module wit_props
(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire standby_in,
    input wire [15:0] bus_addr_in,
    input wire [15:0] bus_wdata_in,
    input wire bus_wr_in,
    input wire bus_word_in,
    input wire bus_rd_in,
    input wire [7:0] bus_rdata_out,
    input wire interval_irq_out,
    input wire internal_reset_out,
    input wire reset_output_pin_o_out,
    input wire reset_output_pin_oe_out
);
    int int_cnt_ff;
    int pin_cnt_ff;
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // Pulse lengths exceed what a repetition can unroll, so they are counted here.
    always @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            int_cnt_ff <= 0;
            pin_cnt_ff <= 0;
        end
        else
        begin
            int_cnt_ff <= internal_reset_out ? int_cnt_ff + 1 : 0;
            pin_cnt_ff <= reset_output_pin_oe_out ? pin_cnt_ff + 1 : 0;
        end
    end
    chk_int_rst_len: assert property ($fell(internal_reset_out) |-> int_cnt_ff == 518)
        else $error("internal reset pulse has the wrong length");
    chk_int_rst_bound: assert property (int_cnt_ff <= 518)
        else $error("internal reset pulse runs too long");
    chk_pin_len: assert property ($fell(reset_output_pin_oe_out) |-> pin_cnt_ff == 132)
        else $error("reset output pulse has the wrong length");
    chk_pin_with_reset: assert property ($rose(reset_output_pin_oe_out) |-> $rose(internal_reset_out))
        else $error("reset output starts apart from internal reset");
    chk_pin_drive_low: assert property (reset_output_pin_oe_out |-> !reset_output_pin_o_out && internal_reset_out)
        else $error("reset output driven wrongly");
    chk_wd_no_irq: assert property ($rose(internal_reset_out) |-> !interval_irq_out)
        else $error("interval request raised in watchdog mode");
    chk_irq_fall_cause: assert property ($fell(interval_irq_out) |-> $past(bus_wr_in) || $past(standby_in))
        else $error("interval request dropped without a write");
    chk_rdata_hold: assert property (!$past(bus_rd_in) |-> $stable(bus_rdata_out))
        else $error("read data changed without a read");
    chk_ctrl_rsvd: assert property (bus_rd_in && bus_addr_in == 16'hffa8 |=> bus_rdata_out[4:3] == 2'h3)
        else $error("reserved control bits not one");
    chk_unmapped_rd: assert property (bus_rd_in && bus_addr_in == 16'hffaa |=> bus_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    cover property ($rose(interval_irq_out));
    cover property ($rose(reset_output_pin_oe_out));
    cover property ($fell(internal_reset_out));
endmodule // wit_props
bind wit_top wit_props wit_props_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .standby_in(standby_in), .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in),
    .bus_wr_in(bus_wr_in), .bus_word_in(bus_word_in), .bus_rd_in(bus_rd_in),
    .bus_rdata_out(bus_rdata_out), .interval_irq_out(interval_irq_out),
    .internal_reset_out(internal_reset_out), .reset_output_pin_o_out(reset_output_pin_o_out),
    .reset_output_pin_oe_out(reset_output_pin_oe_out));

//--- verification/wit_ext_device.sv
`timescale 1ns/1ps
module wit_ext_device
(
    input wire ref_clk_in,
    input wire pin_o_in,
    input wire pin_oe_in,
    output int low_len_out,
    output int pulses_out
);
    int run_len;
    // The pin is open drain, so a released line floats up to the pull-up level.
    wire pin_level = pin_oe_in ? pin_o_in : 1'b1;
    initial
    begin
        run_len = 0;
        low_len_out = 0;
        pulses_out = 0;
    end
    always @(posedge ref_clk_in)
    begin
        if (pin_level === 1'b0)
            run_len <= run_len + 1;
        else if (run_len != 0)
        begin
            low_len_out <= run_len;
            pulses_out <= pulses_out + 1;
            run_len <= 0;
        end
    end
endmodule // wit_ext_device

//--- verification/watchdog_interval_timer_tb_top.sv
`timescale 1ns/1ps
module watchdog_interval_timer_tb_top;
    logic ref_clk;
    logic rst_n = 1'b0;
    logic standby = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic word = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    wire [7:0] rdata;
    wire irq;
    wire int_rst;
    wire pin_o;
    wire pin_oe;
    int low_len;
    int pulses;
    int mismatches = 0;
    int checks = 0;
    int n;
    int m;
    logic [7:0] x;
    logic [7:0] exp_q[$];
    int divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
    wit_top wit_top_inst (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .standby_in(standby),
        .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_wr_in(wr), .bus_word_in(word),
        .bus_rd_in(rd), .bus_rdata_out(rdata), .interval_irq_out(irq),
        .internal_reset_out(int_rst), .reset_output_pin_o_out(pin_o),
        .reset_output_pin_oe_out(pin_oe));
    wit_ext_device wit_ext_device_inst (.ref_clk_in(ref_clk), .pin_o_in(pin_o),
        .pin_oe_in(pin_oe), .low_len_out(low_len), .pulses_out(pulses));
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wr_word(input logic [15:0] a, input logic [15:0] d, input logic w = 1'b1);
        @(negedge ref_clk);
        addr = a;
        wdata = d;
        word = w;
        wr = 1'b1;
        @(negedge ref_clk);
        wr = 1'b0;
    endtask
    task automatic rd_byte(input logic [15:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        addr = a;
        rd = 1'b1;
        exp_q.push_back(e);
        @(negedge ref_clk);
        rd = 1'b0;
    endtask
    // Read data is registered at the read edge, so it is looked at half a cycle later.
    always @(posedge ref_clk)
        rd_d <= rd;
    always @(negedge ref_clk)
        if (rd_d && exp_q.size() > 0)
            check("read data", rdata, exp_q.pop_front());
    task automatic wd_fire(input int pin_pulses);
        wr_word(16'hffa8, 16'ha560);
        wr_word(16'hffa8, 16'h5aff);
        n = 0;
        while (int_rst !== 1'b1 && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("watchdog reset", int_rst, 1'b1);
        n = 0;
        while (int_rst === 1'b1 && n < 600)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("internal reset length", n, 518);
        check("reset pin pulses", pulses, pin_pulses);
        rd_byte(16'hffa8, 8'h18);
    endtask
    initial
    begin
        void'($urandom(91));
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd_byte(16'hffa8, 8'h18);
        rd_byte(16'hffa9, 8'h00);
        rd_byte(16'hffab, 8'h3f);
        rd_byte(16'hffaa, 8'h00);
        wr_word(16'hffa8, 16'h5a33);
        wr_word(16'hffa8, 16'h12a7);
        rd_byte(16'hffa9, 8'h00);
        rd_byte(16'hffa8, 8'h18);
        wr_word(16'hffa8, 16'ha5e7, 1'b0);
        rd_byte(16'hffa8, 8'h18);
        // Any window of divide times m cycles holds exactly m ticks, whatever the phase.
        for (int s = 0; s < 8; s++)
        begin
            m = $urandom_range(3, 1);
            x = 8'($urandom_range(240, 0));
            wr_word(16'hffa8, {8'ha5, 8'h20 | 8'(s)});
            wr_word(16'hffa8, {8'h5a, x});
            repeat (divs[s] * m - 1) @(negedge ref_clk);
            rd_byte(16'hffa9, x + 8'(m));
        end
        wr_word(16'hffa8, 16'ha500);
        rd_byte(16'hffa9, 8'h00);
        wr_word(16'hffa8, 16'ha520);
        wr_word(16'hffa8, 16'h5aff);
        repeat (4) @(negedge ref_clk);
        check("interval request", irq, 1'b1);
        wr_word(16'hffa8, 16'ha520);
        rd_byte(16'hffa8, 8'hb8);
        wr_word(16'hffa8, 16'ha5a0);
        rd_byte(16'hffa8, 8'hb8);
        wr_word(16'hffa8, 16'ha520);
        rd_byte(16'hffa8, 8'h38);
        check("interval request", irq, 1'b0);
        wr_word(16'hffa8, 16'ha527);
        standby = 1'b1;
        rd_byte(16'hffa8, 8'h1f);
        standby = 1'b0;
        wr_word(16'hffaa, 16'h5a40);
        wr_word(16'hffaa, 16'h5a00, 1'b0);
        rd_byte(16'hffab, 8'h7f);
        wd_fire(1);
        check("reset pin length", low_len, 132);
        rd_byte(16'hffab, 8'hff);
        wr_word(16'hffaa, 16'ha501);
        rd_byte(16'hffab, 8'hff);
        wr_word(16'hffaa, 16'ha500);
        rd_byte(16'hffab, 8'h7f);
        wr_word(16'hffaa, 16'h5a00);
        rd_byte(16'hffab, 8'h3f);
        wd_fire(1);
        rd_byte(16'hffab, 8'hbf);
        rst_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd_byte(16'hffab, 8'h3f);
        repeat (2) @(negedge ref_clk);
        results();
    end
    initial
    begin
        repeat (80000) @(posedge ref_clk);
        mismatches++;
        results();
    end
endmodule // watchdog_interval_timer_tb_top
